// File: common/iscd_map.vh
// opcode fields, function codes and multiply/divide timing for the integer control decoder
`ifndef ISCD_MAP_VH
`define ISCD_MAP_VH
`define ISCD_OP_HI 31
`define ISCD_OP_LO 26
`define ISCD_RS_HI 25
`define ISCD_RS_LO 21
`define ISCD_RT_HI 20
`define ISCD_RT_LO 16
`define ISCD_RD_HI 15
`define ISCD_RD_LO 11
`define ISCD_FN_HI 5
`define ISCD_FN_LO 0
`define ISCD_IMM_HI 15
`define ISCD_TGT_HI 25
`define ISCD_SIGN32 31
`define ISCD_CC_HI 20
`define ISCD_CC_LO 18
`define ISCD_TF_BIT 16
`define ISCD_ND_BIT 17
`define ISCD_OP_SPECIAL 6'h00
`define ISCD_OP_REGIMM 6'h01
`define ISCD_OP_J 6'h02
`define ISCD_OP_JAL 6'h03
`define ISCD_OP_BEQ 6'h04
`define ISCD_OP_BGTZ 6'h07
`define ISCD_OP_BEQL 6'h14
`define ISCD_OP_BGTZL 6'h17
`define ISCD_OP_SYSTEM_CONTROL_UNIT 6'h10
`define ISCD_OP_COP1 6'h11
`define ISCD_OP_COP1X 6'h13
`define ISCD_OP_HINT_FETCH_OFFSET 6'h33
`define ISCD_OP_LD_LO 6'h20
`define ISCD_OP_ST_HI 6'h3F
`define ISCD_FN_MOVCI 6'h01
`define ISCD_FN_JR 6'h08
`define ISCD_FN_JALR 6'h09
`define ISCD_FN_MOVE_IF_ZERO 6'h0A
`define ISCD_FN_MOVE_IF_NONZERO 6'h0B
`define ISCD_FN_SYSCALL 6'h0C
`define ISCD_FN_BREAK 6'h0D
`define ISCD_FN_READ_HIGH_RESULT 6'h10
`define ISCD_FN_READ_LOW_RESULT 6'h12
`define ISCD_FN_SIGNED_WORD_MULTIPLY 6'h18
`define ISCD_FN_UNSIGNED_WORD_MULTIPLY 6'h19
`define ISCD_FN_DIV 6'h1A
`define ISCD_FN_UNSIGNED_WORD_DIVIDE 6'h1B
`define ISCD_FN_SIGNED_DWORD_MULTIPLY 6'h1C
`define ISCD_FN_UNSIGNED_DWORD_MULTIPLY 6'h1D
`define ISCD_FN_SIGNED_DWORD_DIVIDE 6'h1E
`define ISCD_FN_UNSIGNED_DWORD_DIVIDE 6'h1F
`define ISCD_FN_TRAP_LO 6'h30
`define ISCD_FN_TRAP_HI 6'h37
`define ISCD_RS_BC 5'h08
`define ISCD_CO_BIT 25
`define ISCD_C0_XLATE_READ_INDEXED 6'h01
`define ISCD_C0_XLATE_WRITE_INDEXED 6'h02
`define ISCD_C0_XLATE_WRITE_RANDOM 6'h06
`define ISCD_C0_XLATE_PROBE 6'h08
`define ISCD_C0_EXCEPTION_RETURN 6'h18
`define ISCD_C0_WAIT 6'h20
`define ISCD_X_LWX 6'h00
`define ISCD_X_LDX 6'h01
`define ISCD_X_SWX 6'h08
`define ISCD_X_SDX 6'h09
`define ISCD_X_HINT_FETCH_INDEXED 6'h0F
`define ISCD_X_MADD_LO 6'h20
`define ISCD_X_MADD_HI 6'h3F
`define ISCD_LAT_MUL16 7'h04
`define ISCD_REP_MUL16 7'h03
`define ISCD_LAT_MUL32 7'h05
`define ISCD_REP_MUL32 7'h04
`define ISCD_LAT_DIV32 7'h24
`define ISCD_REP_DIV32 7'h24
`define ISCD_LAT_DMUL 7'h09
`define ISCD_REP_DMUL 7'h08
`define ISCD_LAT_SIGNED_DWORD_DIVIDE 7'h44
`define ISCD_REP_SIGNED_DWORD_DIVIDE 7'h44
`define ISCD_ST_IDLE 2'h0
`define ISCD_ST_IDXLD 2'h1
`endif

// File: rtl/iscd_decoder.v
// integer instruction decoder with branch target logic and multiply/divide interlock
`timescale 1ns/10ps
`include "iscd_map.vh"
module iscd_decoder #(
    parameter CNT_W = 7
) (
    input wire clock, // pipeline clock
    input wire rst_n, // synchronous reset
    input wire issue_valid, // instruction offered
    input wire [31:0] instr, // instruction word
    input wire [63:0] pc, // address of this instruction
    input wire [63:0] rs_val, // general register rs
    input wire [63:0] rt_val, // general register rt
    input wire [63:0] alu_result, // raw result from alu
    input wire word_op, // alu op is 32-bit
    input wire mul16_hint, // rt operand fits 16 bits
    input wire branch_cond, // integer branch condition true
    input wire cc_write, // fp compare writes a code
    input wire [2:0] cc_write_sel, // code selected by compare
    input wire cc_write_val, // compare outcome
    output wire issue_ready, // instruction accepted this cycle
    output reg [1:0] fmt_r, // 0 imm, 1 jump, 2 register
    output reg use_imm_r, // second operand is immediate
    output reg [63:0] imm_r, // sign-extended immediate
    output reg [63:0] wb_data_r, // sign-corrected result
    output reg redirect_r, // fetch redirect valid
    output reg [63:0] target_r, // redirect target
    output reg nullify_slot_r, // discard delay slot effects
    output reg cmove_do_r, // conditional move performed
    output reg fused_round_r, // round product before add
    output reg fp_indexed_r, // fp reg+reg memory op
    output reg reserved_r, // illegal encoding
    output reg nop_r, // executes with no effect
    output reg [5:0] sysop_r, // onehot: exception_return probe read wi wr wait
    output reg standby_r, // processor in standby
    output reg [7:0] cc_r // fp condition codes
);
    // latency gates hi/lo readers, repeat gates the next muldiv
    reg [CNT_W-1:0] lat_r;
    reg [CNT_W-1:0] lat_nxt;
    reg [CNT_W-1:0] rep_r;
    reg [CNT_W-1:0] rep_nxt;
    // second state marks an indexed load already held once
    reg [1:0] st_r;
    reg [1:0] st_nxt;

    // instruction fields
    wire [5:0] op = instr[`ISCD_OP_HI:`ISCD_OP_LO];
    wire [5:0] fn = instr[`ISCD_FN_HI:`ISCD_FN_LO];
    wire [4:0] rs = instr[`ISCD_RS_HI:`ISCD_RS_LO];
    wire [2:0] cc_sel = instr[`ISCD_CC_HI:`ISCD_CC_LO];
    wire [63:0] sext = {{48{instr[`ISCD_IMM_HI]}}, instr[`ISCD_IMM_HI:0]};
    wire [63:0] slot_pc = pc + 64'h0000000000000004;
    wire is_special = (op == `ISCD_OP_SPECIAL);
    wire is_cop1x = (op == `ISCD_OP_COP1X);
    wire rd_hilo = is_special && (fn == `ISCD_FN_READ_HIGH_RESULT || fn == `ISCD_FN_READ_LOW_RESULT);
    wire is_muldiv = is_special && (fn >= `ISCD_FN_SIGNED_WORD_MULTIPLY) && (fn <= `ISCD_FN_UNSIGNED_DWORD_DIVIDE);
    wire idx_load = is_cop1x && (fn == `ISCD_X_LWX || fn == `ISCD_X_LDX);
    // hi/lo readers wait on latency, new muldiv waits on repeat
    wire stall_hilo = rd_hilo && (lat_r != {CNT_W{1'b0}});
    wire stall_md = is_muldiv && (rep_r != {CNT_W{1'b0}});
    wire stall_idx = idx_load && (st_r == `ISCD_ST_IDLE);
    // standby refuses every offer; only reset leaves it
    assign issue_ready = issue_valid
        && !stall_hilo
        && !stall_md
        && !stall_idx
        && !standby_r;
    wire take = issue_ready;

    // timing of the muldiv offered now; short form only for signed word
    reg [CNT_W-1:0] md_lat;
    reg [CNT_W-1:0] md_rep;
    always @* begin
        md_lat = `ISCD_LAT_MUL32;
        md_rep = `ISCD_REP_MUL32;
        case (fn)
            `ISCD_FN_SIGNED_WORD_MULTIPLY: begin
                // hint comes from the operand path; a wrong hint only mistimes
                if (mul16_hint) begin
                    md_lat = `ISCD_LAT_MUL16;
                    md_rep = `ISCD_REP_MUL16;
                end else begin
                    md_lat = `ISCD_LAT_MUL32;
                    md_rep = `ISCD_REP_MUL32;
                end
            end
            `ISCD_FN_UNSIGNED_WORD_MULTIPLY: begin
                md_lat = `ISCD_LAT_MUL32;
                md_rep = `ISCD_REP_MUL32;
            end
            `ISCD_FN_DIV, `ISCD_FN_UNSIGNED_WORD_DIVIDE: begin
                md_lat = `ISCD_LAT_DIV32;
                md_rep = `ISCD_REP_DIV32;
            end
            `ISCD_FN_SIGNED_DWORD_MULTIPLY, `ISCD_FN_UNSIGNED_DWORD_MULTIPLY: begin
                md_lat = `ISCD_LAT_DMUL;
                md_rep = `ISCD_REP_DMUL;
            end
            `ISCD_FN_SIGNED_DWORD_DIVIDE, `ISCD_FN_UNSIGNED_DWORD_DIVIDE: begin
                md_lat = `ISCD_LAT_SIGNED_DWORD_DIVIDE;
                md_rep = `ISCD_REP_SIGNED_DWORD_DIVIDE;
            end
            default: begin
                md_lat = `ISCD_LAT_MUL32;
                md_rep = `ISCD_REP_MUL32;
            end
        endcase
    end

    always @* begin
        lat_nxt = (lat_r != {CNT_W{1'b0}}) ? lat_r - 1'b1 : lat_r;
        rep_nxt = (rep_r != {CNT_W{1'b0}}) ? rep_r - 1'b1 : rep_r;
        // count includes the issue cycle, so load one less
        if (take && is_muldiv) begin
            lat_nxt = md_lat - 1'b1;
            rep_nxt = md_rep - 1'b1;
        end
    end

    always @* begin
        st_nxt = st_r;
        case (st_r)
            `ISCD_ST_IDLE: begin
                if (issue_valid && stall_idx && !stall_hilo && !stall_md && !standby_r)
                    st_nxt = `ISCD_ST_IDXLD;
            end
            `ISCD_ST_IDXLD: begin
                if (take)
                    st_nxt = `ISCD_ST_IDLE;
            end
            default: st_nxt = `ISCD_ST_IDLE;
        endcase
    end

    // decode outputs, computed combinationally then registered
    reg [1:0] fmt_c;
    reg uimm_c;
    reg redir_c;
    reg null_c;
    reg cmov_c;
    reg fused_c;
    reg fpx_c;
    reg rsv_c;
    reg nop_c;
    reg cc_bit;
    reg [63:0] tgt_c;
    reg [63:0] wb_c;
    reg [5:0] sys_c;
    always @* begin
        fmt_c = 2'h0;
        uimm_c = 1'b1;
        redir_c = 1'b0;
        null_c = 1'b0;
        cmov_c = 1'b0;
        fused_c = 1'b0;
        fpx_c = 1'b0;
        rsv_c = 1'b0;
        nop_c = 1'b0;
        sys_c = 6'h00;
        tgt_c = slot_pc + {sext[61:0], 2'b00};
        cc_bit = cc_r[cc_sel];
        // word ops: trust low half only, replicate bit 31
        wb_c = word_op ? {{32{alu_result[`ISCD_SIGN32]}}, alu_result[31:0]} : alu_result;
        case (op)
            `ISCD_OP_SPECIAL: begin
                fmt_c = 2'h2;
                uimm_c = 1'b0;
                case (fn)
                    `ISCD_FN_JR, `ISCD_FN_JALR: begin
                        // whole 64-bit register, no alignment forced here
                        redir_c = 1'b1;
                        tgt_c = rs_val;
                    end
                    `ISCD_FN_MOVE_IF_ZERO: begin
                        cmov_c = (rt_val == 64'h0000000000000000);
                    end
                    `ISCD_FN_MOVE_IF_NONZERO: begin
                        cmov_c = (rt_val != 64'h0000000000000000);
                    end
                    `ISCD_FN_MOVCI: begin
                        cmov_c = (cc_bit == instr[`ISCD_TF_BIT]);
                    end
                    `ISCD_FN_SYSCALL, `ISCD_FN_BREAK: begin
                        fmt_c = 2'h2;
                    end
                    default: begin
                        if (fn >= `ISCD_FN_TRAP_LO && fn <= `ISCD_FN_TRAP_HI)
                            fmt_c = 2'h2;
                    end
                endcase
            end
            `ISCD_OP_J, `ISCD_OP_JAL: begin
                fmt_c = 2'h1;
                uimm_c = 1'b0;
                redir_c = 1'b1;
                tgt_c = {slot_pc[63:28], instr[`ISCD_TGT_HI:0], 2'b00};
            end
            `ISCD_OP_SYSTEM_CONTROL_UNIT: begin
                if (instr[`ISCD_CO_BIT]) begin
                    case (fn)
                        `ISCD_C0_EXCEPTION_RETURN: sys_c = 6'h01;
                        `ISCD_C0_XLATE_PROBE: sys_c = 6'h02;
                        `ISCD_C0_XLATE_READ_INDEXED: sys_c = 6'h04;
                        `ISCD_C0_XLATE_WRITE_INDEXED: sys_c = 6'h08;
                        `ISCD_C0_XLATE_WRITE_RANDOM: sys_c = 6'h10;
                        `ISCD_C0_WAIT: sys_c = 6'h20;
                        default: rsv_c = 1'b1;
                    endcase
                end
            end
            `ISCD_OP_COP1: begin
                if (rs == `ISCD_RS_BC) begin
                    redir_c = (cc_bit == instr[`ISCD_TF_BIT]);
                    null_c = !redir_c && instr[`ISCD_ND_BIT];
                end
            end
            `ISCD_OP_COP1X: begin
                fmt_c = 2'h2;
                uimm_c = 1'b0;
                if (fn == `ISCD_X_LWX || fn == `ISCD_X_LDX || fn == `ISCD_X_SWX || fn == `ISCD_X_SDX)
                    fpx_c = 1'b1;
                else if (fn == `ISCD_X_HINT_FETCH_INDEXED)
                    nop_c = 1'b1;
                else if (fn >= `ISCD_X_MADD_LO && fn <= `ISCD_X_MADD_HI)
                    fused_c = 1'b1;
                else
                    rsv_c = 1'b1;
            end
            `ISCD_OP_HINT_FETCH_OFFSET: nop_c = 1'b1;
            default: begin
                if ((op >= `ISCD_OP_BEQ && op <= `ISCD_OP_BGTZ) || op == `ISCD_OP_REGIMM) begin
                    redir_c = branch_cond;
                end
                if (op >= `ISCD_OP_BEQL && op <= `ISCD_OP_BGTZL) begin
                    redir_c = branch_cond;
                    null_c = !branch_cond;
                end
                // integer memory ops keep base+offset only
                if (op >= `ISCD_OP_LD_LO && op <= `ISCD_OP_ST_HI)
                    fpx_c = 1'b0;
            end
        endcase
    end

    // muldiv counters and indexed-load state
    always @(posedge clock) begin
        if (!rst_n) begin
            lat_r <= {CNT_W{1'b0}};
            rep_r <= {CNT_W{1'b0}};
            st_r <= `ISCD_ST_IDLE;
        end else begin
            lat_r <= lat_nxt;
            rep_r <= rep_nxt;
            st_r <= st_nxt;
        end
    end

    // codes change only on a compare write or reset, never cleared by decode
    always @(posedge clock) begin
        if (!rst_n)
            cc_r <= 8'h00;
        else if (cc_write)
            cc_r[cc_write_sel] <= cc_write_val;
    end

    // decode results, each valid the cycle after the take edge
    always @(posedge clock) begin
        if (!rst_n) begin
            fmt_r <= 2'h0;
            use_imm_r <= 1'b0;
            imm_r <= 64'h0000000000000000;
            wb_data_r <= 64'h0000000000000000;
            redirect_r <= 1'b0;
            target_r <= 64'h0000000000000000;
            nullify_slot_r <= 1'b0;
            cmove_do_r <= 1'b0;
            fused_round_r <= 1'b0;
            fp_indexed_r <= 1'b0;
            reserved_r <= 1'b0;
            nop_r <= 1'b0;
            sysop_r <= 6'h00;
            standby_r <= 1'b0;
        end else begin
            // result path runs every cycle, independent of issue
            wb_data_r <= wb_c;
            // redirect lands after the slot; slot still issues normally
            fmt_r <= fmt_c;
            use_imm_r <= uimm_c;
            imm_r <= sext;
            redirect_r <= take && redir_c;
            target_r <= tgt_c;
            nullify_slot_r <= take && null_c;
            cmove_do_r <= take && cmov_c;
            fused_round_r <= take && fused_c;
            fp_indexed_r <= take && fpx_c;
            reserved_r <= take && rsv_c;
            nop_r <= take && nop_c;
            sysop_r <= take ? sys_c : 6'h00;
            // standby set by a taken wait and left only by reset; nothing else wakes it
            if (take && sys_c[5])
                standby_r <= 1'b1;
        end
    end
endmodule

// File: dv/iscd_decoder_properties.sv
// port-level checks for the integer control decoder
`timescale 1ns/10ps
module iscd_props (
    input wire logic clock, // clk
    input wire logic rst_n, // reset
    input wire logic issue_valid, // in
    input wire logic [31:0] instr, // in
    input wire logic [63:0] pc, // in
    input wire logic [63:0] rs_val, // in
    input wire logic [63:0] rt_val, // in
    input wire logic [63:0] alu_result, // in
    input wire logic word_op, // in
    input wire logic mul16_hint, // in
    input wire logic branch_cond, // in
    input wire logic cc_write, // in
    input wire logic [2:0] cc_write_sel, // in
    input wire logic cc_write_val, // in
    input wire logic issue_ready, // out
    input wire logic [63:0] wb_data_r, // out
    input wire logic redirect_r, // out
    input wire logic [63:0] target_r, // out
    input wire logic nullify_slot_r, // out
    input wire logic cmove_do_r, // out
    input wire logic standby_r, // out
    input wire logic [7:0] cc_r // out
);
    wire [5:0] op = instr[31:26];
    wire [5:0] fn = instr[5:0];
    wire md = op == 6'h00 && fn[5:3] == 3'h3;
    wire rd = op == 6'h00 && (fn == 6'h10 || fn == 6'h12);
    wire [63:0] pc4 = pc + 64'h4;
    // divides repeat at their latency, multiplies one cycle sooner
    wire [6:0] lv = fn[2:1] == 2'h0 ? ((fn[0] || !mul16_hint) ? 7'h05 : 7'h04) :
        fn[2:1] == 2'h1 ? 7'h24 : fn[2:1] == 2'h2 ? 7'h09 : 7'h44;
    reg [6:0] lat_r;
    reg [6:0] rep_r;
    always @(posedge clock) begin
        if (!rst_n) begin
            lat_r <= 7'h0;
            rep_r <= 7'h0;
        end else if (issue_ready && md) begin
            lat_r <= lv - 7'h1;
            rep_r <= lv - {6'h0, ~fn[1]} - 7'h1;
        end else begin
            lat_r <= lat_r - {6'h0, lat_r != 7'h0};
            rep_r <= rep_r - {6'h0, rep_r != 7'h0};
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    rd_early_a: assert property (issue_ready && rd |-> lat_r == 7'h0) else $error("read taken early");
    rd_late_a: assert property (issue_valid && rd && lat_r == 7'h0 && !standby_r |-> issue_ready)
        else $error("read held too long");
    md_early_a: assert property (issue_ready && md |-> rep_r == 7'h0) else $error("muldiv taken early");
    md_late_a: assert property (issue_valid && md && rep_r == 7'h0 && !standby_r |-> issue_ready)
        else $error("muldiv held too long");
    jump_tgt_a: assert property (issue_ready && op[5:1] == 5'h01 |=> redirect_r &&
        target_r == {$past(pc4[63:28]), $past(instr[25:0]), 2'h0}) else $error("jump target");
    jreg_tgt_a: assert property (issue_ready && op == 6'h00 && fn[5:1] == 5'h04 |=>
        redirect_r && target_r == $past(rs_val)) else $error("register jump target");
    br_tgt_a: assert property (issue_ready && op == 6'h04 && branch_cond |=> redirect_r &&
        target_r == $past(pc4) + {{46{$past(instr[15])}}, $past(instr[15:0]), 2'h0}) else $error("branch target");
    slot_null_a: assert property (issue_ready && (op[5:2] == 4'h1 || op[5:2] == 4'h5) && !branch_cond |=>
        nullify_slot_r == $past(instr[30])) else $error("delay slot nullify");
    word_sext_a: assert property (word_op |=>
        wb_data_r == {{32{$past(alu_result[31])}}, $past(alu_result[31:0])}) else $error("word sign extend");
    idx_stall_a: assert property (issue_valid && op == 6'h13 && fn[5:1] == 5'h00 && !$past(issue_valid)
        |-> !issue_ready) else $error("indexed load not stalled");
    cc_set_a: assert property (cc_write |=> cc_r[$past(cc_write_sel)] == $past(cc_write_val))
        else $error("condition code write");
    cmove_a: assert property (issue_ready && op == 6'h00 && fn[5:1] == 5'h05 |=>
        cmove_do_r == (($past(rt_val) == 64'h0) ^ $past(fn[0]))) else $error("conditional move");
    standby_a: assert property (standby_r |-> !issue_ready) else $error("issue in standby");
endmodule
bind iscd_decoder iscd_props u_iscd_props (.clock(clock), .rst_n(rst_n), .issue_valid(issue_valid),
    .instr(instr), .pc(pc), .rs_val(rs_val), .rt_val(rt_val), .alu_result(alu_result), .word_op(word_op),
    .mul16_hint(mul16_hint), .branch_cond(branch_cond), .cc_write(cc_write), .cc_write_sel(cc_write_sel),
    .cc_write_val(cc_write_val), .issue_ready(issue_ready), .wb_data_r(wb_data_r), .redirect_r(redirect_r),
    .target_r(target_r), .nullify_slot_r(nullify_slot_r), .cmove_do_r(cmove_do_r), .standby_r(standby_r),
    .cc_r(cc_r));

// File: dv/tb_top.sv
// self-checking bench for the integer control decoder
`timescale 1ns/10ps
module tb_top;
    typedef struct {logic [31:0] ins; logic [63:0] v; logic bc; logic [4:0] fl; logic [1:0] fm;
        logic [5:0] so; int w;} iscd_row_t;
    localparam logic [63:0] pc0 = 64'h0FFF_FFFC;
    localparam logic [63:0] rs0 = 64'hFFFF_FFFF_8000_0010;
    logic clock = 1'h0, rst_n = 1'h0, issue_valid = 1'h0, word_op = 1'h0, mul16_hint = 1'h0;
    logic branch_cond = 1'h0, cc_write = 1'h0, cc_write_val = 1'h0;
    logic [2:0] cc_write_sel = 3'h0;
    logic [31:0] instr = 32'h0;
    logic [63:0] pc = 64'h0, rs_val = 64'h0, rt_val = 64'h0, alu_result = 64'h0;
    wire issue_ready, use_imm_r, redirect_r, nullify_slot_r, cmove_do_r, fused_round_r;
    wire fp_indexed_r, reserved_r, nop_r, standby_r;
    wire [1:0] fmt_r;
    wire [63:0] imm_r, wb_data_r, target_r;
    wire [5:0] sysop_r;
    wire [7:0] cc_r;
    int fails = 0, tests_run = 0, n;
    // v is the rt value for moves and the expected target for redirects
    iscd_row_t rows [$] = '{
        '{32'h2022_8000, 64'h0, 1'h0, 5'h00, 2'h0, 6'h00, 0}, '{32'h0BFF_FFFF, 64'h1FFF_FFFC, 1'h0, 5'h10, 2'h1, 6'h00, 0},
        '{32'h0020_0008, rs0, 1'h0, 5'h10, 2'h2, 6'h00, 0}, '{32'h1022_FFFE, 64'h0FFF_FFF8, 1'h1, 5'h10, 2'h0, 6'h00, 0},
        '{32'h1022_FFFE, 64'h0, 1'h0, 5'h00, 2'h0, 6'h00, 0}, '{32'h5022_FFFE, 64'h0, 1'h0, 5'h08, 2'h0, 6'h00, 0},
        '{32'h5022_FFFE, 64'h0FFF_FFF8, 1'h1, 5'h10, 2'h0, 6'h00, 0}, '{32'h0022_180A, 64'h0, 1'h0, 5'h04, 2'h2, 6'h00, 0},
        '{32'h0022_180A, 64'h5, 1'h0, 5'h00, 2'h2, 6'h00, 0}, '{32'h0022_180B, 64'h5, 1'h0, 5'h04, 2'h2, 6'h00, 0},
        '{32'h0035_1801, 64'h0, 1'h0, 5'h04, 2'h2, 6'h00, 0}, '{32'h0034_1801, 64'h0, 1'h0, 5'h00, 2'h2, 6'h00, 0},
        '{32'h0000_000C, 64'h0, 1'h0, 5'h00, 2'h2, 6'h00, 0}, '{32'h0022_0034, 64'h0, 1'h0, 5'h00, 2'h2, 6'h00, 0},
        '{32'hCC22_0000, 64'h0, 1'h0, 5'h01, 2'h0, 6'h00, 0}, '{32'h4C22_000F, 64'h0, 1'h0, 5'h01, 2'h3, 6'h00, 0},
        '{32'h4C22_0100, 64'h0, 1'h0, 5'h00, 2'h3, 6'h00, 1}, '{32'h4C22_2020, 64'h0, 1'h0, 5'h02, 2'h3, 6'h00, 0},
        '{32'h4200_0001, 64'h0, 1'h0, 5'h00, 2'h3, 6'h04, 0}, '{32'h4200_0002, 64'h0, 1'h0, 5'h00, 2'h3, 6'h08, 0},
        '{32'h4200_0006, 64'h0, 1'h0, 5'h00, 2'h3, 6'h10, 0}, '{32'h4200_0008, 64'h0, 1'h0, 5'h00, 2'h3, 6'h02, 0},
        '{32'h4200_0018, 64'h0, 1'h0, 5'h00, 2'h3, 6'h01, 0}, '{32'h8C22_0000, 64'h0, 1'h0, 5'h00, 2'h0, 6'h00, 0}};
    // {function, hint, latency, repeat}
    logic [31:0] md [9] = '{32'h1801_0403, 32'h1800_0504, 32'h1900_0504, 32'h1A00_2424, 32'h1B00_2424,
        32'h1C00_0908, 32'h1D00_0908, 32'h1E00_4444, 32'h1F00_4444};
    iscd_decoder u_iscd_decoder (.clock(clock), .rst_n(rst_n), .issue_valid(issue_valid), .instr(instr), .pc(pc),
        .rs_val(rs_val), .rt_val(rt_val), .alu_result(alu_result), .word_op(word_op), .mul16_hint(mul16_hint),
        .branch_cond(branch_cond), .cc_write(cc_write), .cc_write_sel(cc_write_sel), .cc_write_val(cc_write_val),
        .issue_ready(issue_ready), .fmt_r(fmt_r), .use_imm_r(use_imm_r), .imm_r(imm_r), .wb_data_r(wb_data_r),
        .redirect_r(redirect_r), .target_r(target_r), .nullify_slot_r(nullify_slot_r), .cmove_do_r(cmove_do_r),
        .fused_round_r(fused_round_r), .fp_indexed_r(fp_indexed_r), .reserved_r(reserved_r), .nop_r(nop_r),
        .sysop_r(sysop_r), .standby_r(standby_r), .cc_r(cc_r));
    always #4 clock = ~clock;
    task chk(input logic [63:0] s, input logic [63:0] e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %0t seen %h want %h", $time, s, e);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // returns how many cycles the offer was refused; ends just after the take edge
    task issue(input logic [31:0] i, input logic [63:0] b, input logic c, output int w);
        w = 0;
        @(posedge clock);
        instr <= i;
        pc <= pc0;
        rs_val <= rs0;
        rt_val <= b;
        branch_cond <= c;
        issue_valid <= 1'h1;
        @(negedge clock);
        while (issue_ready !== 1'h1 && w < 200) begin
            w++;
            @(negedge clock);
        end
        if (w >= 200)
            fails++;
        @(posedge clock);
        issue_valid <= 1'h0;
        @(negedge clock);
    endtask
    initial begin
        #200000;
        fails++;
        summarize;
    end
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'h1;
        @(negedge clock);
        chk({redirect_r, nullify_slot_r, cmove_do_r, nop_r, standby_r, sysop_r, cc_r}, 64'h0);
        @(posedge clock);
        cc_write <= 1'h1;
        cc_write_sel <= 3'h5;
        cc_write_val <= 1'h1;
        @(posedge clock);
        cc_write <= 1'h0;
        @(negedge clock);
        chk(cc_r, 8'h20);
        foreach (rows[k]) begin
            issue(rows[k].ins, rows[k].v, rows[k].bc, n);
            chk({redirect_r, nullify_slot_r, cmove_do_r, fused_round_r, nop_r}, rows[k].fl);
            if (rows[k].fm != 2'h3)
                chk(fmt_r, rows[k].fm);
            if (rows[k].fl[4])
                chk(target_r, rows[k].v);
            chk(sysop_r, rows[k].so);
            chk(n, rows[k].w);
            chk({fp_indexed_r, reserved_r}, {rows[k].w[0], 1'h0});
        end
        foreach (md[k]) begin
            @(posedge clock);
            mul16_hint <= md[k][16];
            issue({16'h0022, 10'h0, md[k][29:24]}, 64'h0, 1'h0, n);
            issue({16'h0022, 10'h0, md[k][29:24]}, 64'h0, 1'h0, n);
            chk(n, md[k][7:0] - 2);
            issue(32'h0000_0010, 64'h0, 1'h0, n);
            chk(n, md[k][15:8] - 2);
            issue(32'h0000_0012, 64'h0, 1'h0, n);
            chk(n, 0);
        end
        @(posedge clock);
        alu_result <= 64'h1_8000_0001;
        word_op <= 1'h1;
        @(posedge clock);
        word_op <= 1'h0;
        @(negedge clock);
        chk(wb_data_r, 64'hFFFF_FFFF_8000_0001);
        @(negedge clock);
        chk(wb_data_r, 64'h1_8000_0001);
        issue(32'h4200_003F, 64'h0, 1'h0, n);
        chk({reserved_r, sysop_r}, 7'h40);
        issue(32'h4200_0020, 64'h0, 1'h0, n);
        chk({sysop_r, standby_r}, 7'h41);
        // standby only leaves through reset, so every offer must stay refused
        @(posedge clock);
        issue_valid <= 1'h1;
        instr <= 32'h2022_8000;
        repeat (3) @(negedge clock);
        chk(issue_ready, 1'h0);
        @(posedge clock);
        issue_valid <= 1'h0;
        rst_n <= 1'h0;
        repeat (5) @(posedge clock);
        rst_n <= 1'h1;
        @(negedge clock);
        chk({standby_r, cc_r}, 9'h0);
        issue(32'h2022_8000, 64'h0, 1'h0, n);
        chk({n[1:0], fmt_r}, 4'h0);
        chk(use_imm_r, 1'h1);
        chk(imm_r, 64'hFFFF_FFFF_FFFF_8000);
        summarize;
    end
endmodule
